/* mdm_pkg.sv */
// Package: register map, field layout, timing and types of the modem option registers
`default_nettype none
package mdm_pkg;
	localparam int NREG = 20;
	localparam int IX_TERM = 0;
	localparam int IX_LF = 1;
	localparam int IX_ERASE = 2;
	localparam int IX_DIAL = 3;
	localparam int IX_CWAIT = 4;
	localparam int IX_COMMA = 5;
	localparam int IX_QUAL = 6;
	localparam int IX_LOSS = 7;
	localparam int IX_GUARD = 9;
	localparam int IX_GEN = 10;
	localparam int IX_TEST = 11;
	localparam int IX_TDUR = 12;
	localparam int IX_SER = 13;
	localparam int IX_SPK = 14;
	localparam int IX_RATE = 15;
	localparam int IX_SLEEP = 16;
	localparam int IX_DTR = 17;
	localparam int IX_CTS = 18;
	localparam int IX_SYNC = 19;
	localparam logic [4:0] IX_NONE = 5'h1f;
	// Register numbers as used by the set and read commands
	localparam logic [7:0] REG_NUM [NREG] = '{
		8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c,
		8'h0e, 8'h10, 8'h12, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h1b};
	localparam logic [7:0] REG_RST [NREG] = '{
		8'h0d, 8'h0a, 8'h08, 8'h04, 8'h32, 8'h02, 8'h06, 8'h0e, 8'h00, 8'h32,
		8'h8a, 8'h00, 8'h00, 8'h04, 8'h75, 8'hb7, 8'h00, 8'h05, 8'h01, 8'h09};
	// Field positions
	localparam int GEN_ECHO = 1;
	localparam int GEN_QUIET = 2;
	localparam int GEN_VERB = 3;
	localparam int GEN_PULSE = 5;
	localparam int GEN_ORIG = 7;
	localparam int SER_CTS = 2;
	localparam int SER_DTR = 3;
	localparam int SER_CD = 5;
	localparam int SER_DSR = 6;
	localparam int SER_LSD = 7;
	localparam int SPK_VOL = 0;
	localparam int SPK_CTL = 2;
	localparam int SPK_RES = 4;
	localparam int RATE_RDL = 0;
	localparam int RATE_DTE = 1;
	localparam int RATE_PAR = 4;
	localparam int RATE_GT = 6;
	localparam int SYN_M = 0;
	localparam int SYN_LEASE = 2;
	localparam int SYN_Q = 3;
	localparam int SYN_CLK = 4;
	localparam int SYN_BELL = 6;
	// Character and timing constants
	localparam logic [7:0] ERASE_MAX = 8'h20;
	localparam logic [7:0] ASCII_SPACE = 8'h20;
	localparam logic [7:0] DIAL_MIN_S = 8'h02;
	localparam logic [7:0] LOSS_NEVER = 8'hff;
	localparam int CLK_NS = 100;
	localparam int TICK_NS = 10000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_NS;
	typedef enum logic [3:0] {
		HUP_NONE = 4'b0001,
		HUP_NO_CARRIER = 4'b0010,
		HUP_CARRIER_LOST = 4'b0100,
		HUP_DTR = 4'b1000
	} mdm_hup_t;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] num;
		logic [7:0] wdata;
	} mdm_req_t;
	typedef struct packed {
		logic valid;
		logic hit;
		logic [7:0] data;
		logic [11:0] digits;
	} mdm_rsp_t;
	typedef struct packed {
		logic valid;
		logic [7:0] code;
	} mdm_char_t;
	typedef struct packed {
		logic sync_mode;
		logic pulse;
		logic originate;
		logic leased;
		logic [1:0] clk_src;
		logic bell;
		logic [1:0] spk_vol;
		logic [1:0] spk_ctl;
		logic [2:0] result_set;
		logic [1:0] dtr_mode;
		logic cd_mode;
		logic dsr_mode;
		logic long_space;
		logic rdl_grant;
		logic [2:0] host_rate;
		logic [1:0] parity;
		logic [1:0] guard_tone;
	} mdm_cfg_t;
endpackage
`default_nettype wire

/* mdm_option_regs.sv */
// Modem option register bank with call-progress timers and line handling
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// (R1) Terminator code ends lines, async only
// (R2) Verbose results append line feed after terminator
// (R3) Backspace recognised only when code <= 32
// (R4) Echoed backspace sends backspace, space, backspace
// (R5) Pause dial delay, minimum 2 s
// (R6) Carrier wait timer hangs up without carrier
// (R7) Answer tone restarts carrier wait in originate
// (R8) Pause modifier waits pause register seconds
// (R9) Carrier detect after qualify tenths continuous
// (R10) Loss delay hangs up; 255 never
// (R11) Disconnect wait is loss minus qualify
// (R12) Escape accepted within guard time gap
// (R13) General options reset 138, field layout
// (R14) Test status resets 0, flags active test
// (R15) Test ends after timer; 0 waits
// (R16) Serial options reset 4, field layout
// (R17) Speaker/result options reset 117, layout
// (R18) Rate/parity options reset 183, layout
// (R19) Sleep after idle tens of seconds
// (R20) Ignore DTR drop for delay value
// (R21) Sync always-on CTS delayed after RTS
// (R22) Sync/clock options reset 9, layout
// (R23) Set and three-digit read commands
module mdm_option_regs #(
	parameter int unsigned TICK_CYC = mdm_pkg::TICK_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire mdm_pkg::mdm_req_t i_req,
	output mdm_pkg::mdm_rsp_t o_rsp,
	input wire mdm_pkg::mdm_char_t i_rx,
	output logic o_erase_hit,
	output mdm_pkg::mdm_char_t o_tx,
	input wire logic i_tx_ready,
	input wire logic i_result_end,
	input wire logic i_off_hook,
	input wire logic i_wait_dial_tone,
	input wire logic i_dial_tone,
	output logic o_dial_go,
	input wire logic i_dial_done,
	input wire logic i_answer_tone,
	input wire logic i_answer_tone_ok,
	input wire logic i_online,
	input wire logic i_quiet_answer,
	input wire logic i_silence,
	output logic o_quiet_timeout,
	input wire logic i_comma,
	output logic o_comma_busy,
	input wire logic i_carrier,
	output logic o_carrier_detect,
	input wire logic i_esc_char,
	output logic o_esc_ok,
	input wire logic i_test_start,
	input wire logic [7:0] i_test_bits,
	input wire logic i_test_end,
	output logic o_test_active,
	output logic o_test_done,
	input wire logic i_activity,
	output logic o_sleep,
	input wire logic i_dtr,
	input wire logic i_rts,
	output logic o_cts,
	output logic o_hangup,
	output mdm_pkg::mdm_hup_t o_hangup_cause,
	output mdm_pkg::mdm_cfg_t o_cfg
);
	import mdm_pkg::*;
	localparam int DW = $clog2(TICK_CYC);

	function automatic logic [4:0] reg_ix(input logic [7:0] n);
		logic [4:0] r;
		r = IX_NONE;
		for (int k = 0; k < NREG; k++) begin
			if (REG_NUM[k] == n) begin
				r = 5'(k);
			end
		end
		return r;
	endfunction

	function automatic logic [11:0] to_digits(input logic [7:0] v);
		logic [7:0] h;
		logic [7:0] t;
		h = v / 8'd100;
		t = (v % 8'd100) / 8'd10;
		return {h[3:0], t[3:0], 4'(v % 8'd10)};
	endfunction

	logic [7:0] regs_r [NREG];
	logic [4:0] wr_ix;
	logic [4:0] rd_ix;
	logic [DW-1:0] div_r;
	logic tick_h;
	logic [3:0] d_t;
	logic [3:0] d_s;
	logic [3:0] d_x;
	logic tick_t;
	logic tick_s;
	logic tick_x;
	logic [2:0] s1_r;
	logic [2:0] s2_r;
	logic car_s;
	logic dtr_s;
	logic rts_s;
	logic sync_m;
	logic echo;
	logic erase_hit;
	logic [7:0] q_r [3];
	logic [1:0] q_n_r;
	logic [8:0] dp_cnt_r;
	logic dp_run_r;
	logic dp_tone_r;
	logic [7:0] cw_cnt_r;
	logic cw_run_r;
	logic cw_exp;
	logic [7:0] qa_cnt_r;
	logic qa_run_r;
	logic [7:0] cp_cnt_r;
	logic [7:0] qc_cnt_r;
	logic cd_r;
	logic cd_q_r;
	logic [7:0] loss_wait;
	logic [7:0] ls_cnt_r;
	logic ls_run_r;
	logic ls_exp;
	logic [7:0] esc_gap_r;
	logic esc_seen_r;
	logic [7:0] te_cnt_r;
	logic te_run_r;
	logic te_end;
	logic [7:0] sl_cnt_r;
	logic [7:0] dt_cnt_r;
	logic dt_done_r;
	logic dt_exp;
	logic [7:0] rt_cnt_r;
	logic cts_dly_r;

	assign wr_ix = reg_ix(i_req.num);
	assign rd_ix = reg_ix(i_req.num);
	assign sync_m = !regs_r[IX_SYNC][SYN_Q] && (regs_r[IX_SYNC][SYN_M+:2] != 2'd0); // R22
	assign echo = regs_r[IX_GEN][GEN_ECHO];
	assign tick_t = tick_h && (d_t == 4'd9);
	assign tick_s = tick_t && (d_s == 4'd9);
	assign tick_x = tick_s && (d_x == 4'd9);
	assign car_s = s2_r[0];
	assign dtr_s = s2_r[1];
	assign rts_s = s2_r[2];

	// Register storage; test events override a same-cycle write
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			for (int i = 0; i < NREG; i++) begin
				regs_r[i] <= REG_RST[i]; // R13 R14 R16 R17 R18 R22
			end
		end else begin
			if (i_req.wr && wr_ix != IX_NONE) begin
				regs_r[wr_ix] <= i_req.wdata; // R23
			end
			if (te_end) begin
				regs_r[IX_TEST] <= 8'h00; // R14
			end else if (i_test_start) begin
				regs_r[IX_TEST] <= i_test_bits; // R14
			end
		end
	end

	// Command answer with value in three decimal digits
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rsp <= '0;
		end else begin
			o_rsp.valid <= i_req.rd || i_req.wr;
			o_rsp.hit <= rd_ix != IX_NONE;
			o_rsp.data <= (rd_ix != IX_NONE) ? regs_r[rd_ix] : 8'h00;
			o_rsp.digits <= to_digits((rd_ix != IX_NONE) ? regs_r[rd_ix] : 8'h00); // R23
		end
	end

	// Option fields
	always_comb begin
		o_cfg = '0;
		o_cfg.sync_mode = sync_m;
		o_cfg.pulse = regs_r[IX_GEN][GEN_PULSE]; // R13
		o_cfg.originate = regs_r[IX_GEN][GEN_ORIG]; // R13
		o_cfg.leased = regs_r[IX_SYNC][SYN_LEASE]; // R22
		o_cfg.clk_src = regs_r[IX_SYNC][SYN_CLK+:2]; // R22
		o_cfg.bell = regs_r[IX_SYNC][SYN_BELL]; // R22
		o_cfg.spk_vol = regs_r[IX_SPK][SPK_VOL+:2]; // R17
		o_cfg.spk_ctl = regs_r[IX_SPK][SPK_CTL+:2]; // R17
		o_cfg.result_set = regs_r[IX_SPK][SPK_RES+:3]; // R17
		o_cfg.dtr_mode = regs_r[IX_SER][SER_DTR+:2]; // R16
		o_cfg.cd_mode = regs_r[IX_SER][SER_CD]; // R16
		o_cfg.dsr_mode = regs_r[IX_SER][SER_DSR]; // R16
		o_cfg.long_space = regs_r[IX_SER][SER_LSD]; // R16
		o_cfg.rdl_grant = regs_r[IX_RATE][RATE_RDL]; // R18
		o_cfg.host_rate = regs_r[IX_RATE][RATE_DTE+:3]; // R18
		o_cfg.parity = regs_r[IX_RATE][RATE_PAR+:2]; // R18
		o_cfg.guard_tone = regs_r[IX_RATE][RATE_GT+:2]; // R18
	end

	// Time base: hundredths, tenths, seconds, tens of seconds
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			div_r <= '0;
			tick_h <= 1'b0;
			d_t <= 4'h0;
			d_s <= 4'h0;
			d_x <= 4'h0;
		end else begin
			tick_h <= (div_r == DW'(TICK_CYC - 1));
			div_r <= (div_r == DW'(TICK_CYC - 1)) ? '0 : div_r + 1'b1;
			if (tick_h) d_t <= (d_t == 4'd9) ? 4'd0 : d_t + 4'd1;
			if (tick_t) d_s <= (d_s == 4'd9) ? 4'd0 : d_s + 4'd1;
			if (tick_s) d_x <= (d_x == 4'd9) ? 4'd0 : d_x + 4'd1;
		end
	end

	// Pin synchronisers: carrier, DTR, RTS
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			s1_r <= 3'h0;
			s2_r <= 3'h0;
		end else begin
			s1_r <= {i_rts, i_dtr, i_carrier};
			s2_r <= s1_r;
		end
	end

	// Character handling and transmit queue
	assign erase_hit = i_rx.valid && !sync_m && (regs_r[IX_ERASE] <= ERASE_MAX) // R3
		&& (i_rx.code == regs_r[IX_ERASE]);
	assign o_erase_hit = erase_hit;
	assign o_tx.valid = q_n_r != 2'd0;
	assign o_tx.code = q_r[0];
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			q_n_r <= 2'd0;
			q_r <= '{8'h00, 8'h00, 8'h00};
		end else if (q_n_r == 2'd0) begin
			if (erase_hit && echo) begin
				q_r <= '{regs_r[IX_ERASE], ASCII_SPACE, regs_r[IX_ERASE]}; // R4
				q_n_r <= 2'd3; // R4
			end else if (i_result_end && !sync_m && !regs_r[IX_GEN][GEN_QUIET]) begin
				q_r <= '{regs_r[IX_TERM], regs_r[IX_LF], 8'h00}; // R1 R2
				q_n_r <= regs_r[IX_GEN][GEN_VERB] ? 2'd2 : 2'd1; // R2
			end
		end else if (i_tx_ready) begin
			q_r <= '{q_r[1], q_r[2], 8'h00};
			q_n_r <= q_n_r - 2'd1;
		end
	end

	// Dial pause after off-hook
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			dp_cnt_r <= 9'h000;
			dp_run_r <= 1'b0;
			dp_tone_r <= 1'b0;
			o_dial_go <= 1'b0;
		end else begin
			o_dial_go <= 1'b0;
			if (i_off_hook) begin
				dp_tone_r <= i_wait_dial_tone; // R5
				dp_run_r <= !i_wait_dial_tone;
				dp_cnt_r <= ((regs_r[IX_DIAL] < DIAL_MIN_S) ? 9'(DIAL_MIN_S) : 9'(regs_r[IX_DIAL])) + 9'd1; // R5
			end else if (dp_tone_r && i_dial_tone) begin
				dp_tone_r <= 1'b0;
				o_dial_go <= 1'b1; // R5
			end else if (dp_run_r && tick_s) begin
				dp_cnt_r <= dp_cnt_r - 9'd1;
				if (dp_cnt_r == 9'd1) begin
					dp_run_r <= 1'b0;
					o_dial_go <= 1'b1; // R5
				end
			end
		end
	end

	// Carrier wait and quiet-answer silence wait
	assign cw_exp = cw_run_r && !cd_r && tick_s && (cw_cnt_r <= 8'd1);
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cw_cnt_r <= 8'h00;
			cw_run_r <= 1'b0;
		end else if ((i_dial_done && regs_r[IX_GEN][GEN_ORIG]) || (i_off_hook && !regs_r[IX_GEN][GEN_ORIG])
				|| (cw_run_r && i_answer_tone && i_answer_tone_ok && regs_r[IX_GEN][GEN_ORIG])) begin
			cw_run_r <= 1'b1; // R6 R7
			cw_cnt_r <= regs_r[IX_CWAIT];
		end else if (cd_r || cw_exp) begin
			cw_run_r <= 1'b0;
		end else if (cw_run_r && tick_s) begin
			cw_cnt_r <= cw_cnt_r - 8'd1;
		end
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			qa_cnt_r <= 8'h00;
			qa_run_r <= 1'b0;
			o_quiet_timeout <= 1'b0;
		end else begin
			o_quiet_timeout <= 1'b0;
			if (i_quiet_answer) begin
				qa_run_r <= 1'b1;
				qa_cnt_r <= regs_r[IX_CWAIT]; // R6
			end else if (i_silence) begin
				qa_run_r <= 1'b0;
			end else if (qa_run_r && tick_s) begin
				qa_cnt_r <= qa_cnt_r - 8'd1;
				if (qa_cnt_r <= 8'd1) begin
					qa_run_r <= 1'b0;
					o_quiet_timeout <= 1'b1; // R6
				end
			end
		end
	end

	// Pause dial modifier
	assign o_comma_busy = cp_cnt_r != 8'h00;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cp_cnt_r <= 8'h00;
		end else if (i_comma) begin
			cp_cnt_r <= regs_r[IX_COMMA]; // R8
		end else if (tick_s && cp_cnt_r != 8'h00) begin
			cp_cnt_r <= cp_cnt_r - 8'd1; // R8
		end
	end

	// Carrier qualify
	assign o_carrier_detect = cd_r;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			qc_cnt_r <= 8'h00;
			cd_r <= 1'b0;
			cd_q_r <= 1'b0;
		end else begin
			cd_q_r <= cd_r;
			if (!car_s) begin
				qc_cnt_r <= regs_r[IX_QUAL]; // R9
				cd_r <= 1'b0;
			end else if (!cd_r && (qc_cnt_r == 8'd0 || (tick_t && qc_cnt_r == 8'd1))) begin
				cd_r <= 1'b1; // R9
			end else if (!cd_r && tick_t) begin
				qc_cnt_r <= qc_cnt_r - 8'd1;
			end
		end
	end

	// Carrier loss hang-up
	assign loss_wait = (regs_r[IX_LOSS] > regs_r[IX_QUAL]) ? regs_r[IX_LOSS] - regs_r[IX_QUAL] : 8'h00; // R11
	assign ls_exp = ls_run_r && !cd_r && i_online && (ls_cnt_r == 8'd0 || (tick_t && ls_cnt_r == 8'd1));
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			ls_cnt_r <= 8'h00;
			ls_run_r <= 1'b0;
		end else if (cd_q_r && !cd_r && i_online) begin
			ls_run_r <= regs_r[IX_LOSS] != LOSS_NEVER; // R10
			ls_cnt_r <= loss_wait; // R11
		end else if (cd_r || !i_online || ls_exp) begin
			ls_run_r <= 1'b0;
		end else if (ls_run_r && tick_t) begin
			ls_cnt_r <= ls_cnt_r - 8'd1; // R10
		end
	end

	// Escape guard gap
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			esc_gap_r <= 8'h00;
			esc_seen_r <= 1'b0;
			o_esc_ok <= 1'b0;
		end else begin
			o_esc_ok <= 1'b0;
			if (i_esc_char) begin
				o_esc_ok <= esc_seen_r && (esc_gap_r <= regs_r[IX_GUARD]); // R12
				esc_gap_r <= 8'h00;
				esc_seen_r <= 1'b1;
			end else if (tick_t && esc_gap_r != 8'hff) begin
				esc_gap_r <= esc_gap_r + 8'd1;
			end
		end
	end

	// Test timer
	assign te_end = te_run_r && (i_test_end || (regs_r[IX_TDUR] != 8'h00 && tick_s && te_cnt_r <= 8'd1)); // R15
	assign o_test_active = te_run_r;
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			te_cnt_r <= 8'h00;
			te_run_r <= 1'b0;
			o_test_done <= 1'b0;
		end else begin
			o_test_done <= te_end;
			if (te_end) begin
				te_run_r <= 1'b0; // R15
			end else if (i_test_start) begin
				te_run_r <= 1'b1;
				te_cnt_r <= regs_r[IX_TDUR]; // R15
			end else if (te_run_r && tick_s) begin
				te_cnt_r <= te_cnt_r - 8'd1;
			end
		end
	end

	// Sleep inactivity
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sl_cnt_r <= 8'h00;
			o_sleep <= 1'b0;
		end else if (i_activity) begin
			sl_cnt_r <= 8'h00; // R19
			o_sleep <= 1'b0;
		end else begin
			if (tick_x && sl_cnt_r != 8'hff) sl_cnt_r <= sl_cnt_r + 8'd1;
			o_sleep <= (regs_r[IX_SLEEP] != 8'h00) && (sl_cnt_r >= regs_r[IX_SLEEP]); // R19
		end
	end

	// DTR drop ignore window
	assign dt_exp = i_online && !dtr_s && !dt_done_r && (dt_cnt_r >= regs_r[IX_DTR]); // R20
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			dt_cnt_r <= 8'h00;
			dt_done_r <= 1'b0;
		end else if (dtr_s || !i_online) begin
			dt_cnt_r <= 8'h00;
			dt_done_r <= 1'b0;
		end else if (dt_exp) begin
			dt_done_r <= 1'b1;
		end else if ((sync_m ? tick_s : tick_h) && dt_cnt_r != 8'hff) begin
			dt_cnt_r <= dt_cnt_r + 8'd1; // R20
		end
	end

	// CTS: track RTS, else held on in async always-on mode, or delayed in synchronous always-on mode
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rt_cnt_r <= 8'h00;
			cts_dly_r <= 1'b0;
			o_cts <= 1'b0;
		end else begin
			if (!rts_s) begin
				rt_cnt_r <= 8'h00;
				cts_dly_r <= 1'b0;
			end else if (rt_cnt_r >= regs_r[IX_CTS]) begin
				cts_dly_r <= 1'b1; // R21
			end else if (tick_h) begin
				rt_cnt_r <= rt_cnt_r + 8'd1;
			end
			o_cts <= regs_r[IX_SER][SER_CTS] ? rts_s : (sync_m ? cts_dly_r : 1'b1); // R16 R21
		end
	end

	// Hang-up request with cause
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_hangup <= 1'b0;
			o_hangup_cause <= HUP_NONE;
		end else begin
			o_hangup <= cw_exp || ls_exp || dt_exp;
			if (cw_exp) o_hangup_cause <= HUP_NO_CARRIER; // R6
			else if (ls_exp) o_hangup_cause <= HUP_CARRIER_LOST; // R10
			else if (dt_exp) o_hangup_cause <= HUP_DTR; // R20
		end
	end

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	property p_erase_echo;
		erase_hit && echo && q_n_r == 2'd0 |=> q_n_r == 2'd3 && q_r[0] == $past(i_rx.code)
			&& q_r[1] == ASCII_SPACE && q_r[2] == $past(i_rx.code);
	endproperty
	a_erase_echo: assert property (p_erase_echo) else $error("erase echo not three chars"); // R4
	property p_lf_after_term;
		i_result_end && q_n_r == 2'd0 && !erase_hit && !sync_m && regs_r[IX_GEN][3:2] == 2'b10
			|=> q_n_r == 2'd2 && q_r[0] == $past(regs_r[IX_TERM]) && q_r[1] == $past(regs_r[IX_LF]);
	endproperty
	a_lf_after_term: assert property (p_lf_after_term) else $error("line feed not after terminator"); // R2
	property p_erase_limit;
		erase_hit |-> regs_r[IX_ERASE] <= 8'd32 && !sync_m;
	endproperty
	a_erase_limit: assert property (p_erase_limit) else $error("backspace above 32 recognised"); // R3
	property p_dial_min;
		i_off_hook && !i_wait_dial_tone |=> dp_run_r && dp_cnt_r >= 9'd3;
	endproperty
	a_dial_min: assert property (p_dial_min) else $error("dial pause below minimum"); // R5
	property p_cd_qualify;
		$rose(cd_r) |-> $past(car_s) && $past(qc_cnt_r) <= 8'd1;
	endproperty
	a_cd_qualify: assert property (p_cd_qualify) else $error("carrier detect before qualify"); // R9
	property p_loss_never;
		o_hangup && o_hangup_cause == HUP_CARRIER_LOST |-> $past(regs_r[IX_LOSS], 2) != 8'd255;
	endproperty
	a_loss_never: assert property (p_loss_never) else $error("hang-up with loss value 255"); // R10
	property p_esc_gap;
		o_esc_ok |-> $past(esc_gap_r) <= $past(regs_r[IX_GUARD]);
	endproperty
	a_esc_gap: assert property (p_esc_gap) else $error("escape accepted past guard"); // R12
	property p_test_hold;
		te_run_r && regs_r[IX_TDUR] == 8'd0 && !i_test_end |=> te_run_r;
	endproperty
	a_test_hold: assert property (p_test_hold) else $error("untimed test ended alone"); // R15
	property p_cts_track;
		regs_r[IX_SER][2] ##1 regs_r[IX_SER][2] |-> o_cts == $past(rts_s);
	endproperty
	a_cts_track: assert property (p_cts_track) else $error("CTS not tracking RTS"); // R16
	property p_sleep_wake;
		i_activity |=> !o_sleep;
	endproperty
	a_sleep_wake: assert property (p_sleep_wake) else $error("sleep despite activity"); // R19

	c_echo: cover property (erase_hit && echo ##1 q_n_r == 2'd3);
	c_hangup: cover property (o_hangup);
	c_esc: cover property (o_esc_ok);
	c_dial: cover property (o_dial_go);
endmodule // mdm_option_regs
`default_nettype wire

/* mdm_host_model.sv */
// Host terminal model that takes characters from the modem
`timescale 1ns/10ps
`default_nettype none
module mdm_host_model (
	input wire logic i_core_clk,
	input wire mdm_pkg::mdm_char_t i_tx,
	output logic o_ready
);
	import mdm_pkg::*;
	logic [7:0] got_q [$];
	initial o_ready = 1'b0;
	// Takes a char at an edge with ready high, stalls at random
	always @(posedge i_core_clk) begin
		if (i_tx.valid === 1'b1 && o_ready === 1'b1) begin
			got_q.push_back(i_tx.code);
		end
		#1 o_ready = ($urandom % 3) != 0;
	end
endmodule // mdm_host_model
`default_nettype wire

/* testbench.sv */
// Testbench for the modem option register bank
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import mdm_pkg::*;
	logic i_core_clk = 1'b0;
	logic i_rst = 1'b1;
	mdm_req_t req = '0;
	mdm_rsp_t rsp;
	mdm_rsp_t got;
	mdm_char_t rx = '0;
	mdm_char_t tx;
	mdm_hup_t cause;
	logic rdy;
	logic res_end = 1'b0;
	logic carrier = 1'b0;
	logic online = 1'b0;
	logic dtr = 1'b1;
	logic hit;
	logic det;
	logic esc_ok;
	logic t_act;
	logic go;
	logic cts;
	logic slp;
	int n_go = 0;
	logic [23:0] z = '0;
	int n_fail = 0;
	int n_tests = 0;
	logic [7:0] mdl [NREG];
	logic [7:0] exp_q [$];
	logic [7:0] rst_tab [NREG] = '{8'h0d, 8'h0a, 8'h08, 8'h04, 8'h32, 8'h02, 8'h06, 8'h0e, 8'h00, 8'h32,
		8'h8a, 8'h00, 8'h00, 8'h04, 8'h75, 8'hb7, 8'h00, 8'h05, 8'h01, 8'h09};
	always #50 i_core_clk = ~i_core_clk;
	mdm_option_regs #(.TICK_CYC(4)) i_mdm_option_regs (
		.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(req), .o_rsp(rsp), .i_rx(rx),
		.o_erase_hit(hit), .o_tx(tx), .i_tx_ready(rdy), .i_result_end(res_end),
		.i_off_hook(z[0]), .i_wait_dial_tone(z[1]), .i_dial_tone(z[2]), .o_dial_go(go),
		.i_dial_done(z[3]), .i_answer_tone(z[4]), .i_answer_tone_ok(z[5]), .i_online(online),
		.i_quiet_answer(z[6]), .i_silence(z[7]), .o_quiet_timeout(), .i_comma(z[8]),
		.o_comma_busy(), .i_carrier(carrier), .o_carrier_detect(det), .i_esc_char(z[9]),
		.o_esc_ok(esc_ok), .i_test_start(z[10]), .i_test_bits(z[23:16]), .i_test_end(z[11]),
		.o_test_active(t_act), .o_test_done(), .i_activity(z[12]), .o_sleep(slp), .i_dtr(dtr),
		.i_rts(z[13]), .o_cts(cts), .o_hangup(), .o_hangup_cause(cause), .o_cfg());
	mdm_host_model i_host (.i_core_clk(i_core_clk), .i_tx(tx), .o_ready(rdy));
	always @(posedge i_core_clk) begin
		if (go === 1'b1) n_go++;
	end
	task automatic end_of_test;
		if (n_fail == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	function automatic logic [11:0] bcd(input int v);
		return {4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
	endfunction
	task automatic access(input logic w, input logic [7:0] n, input logic [7:0] d);
		@(posedge i_core_clk) #1;
		req = '{wr: w, rd: ~w, num: n, wdata: d};
		@(posedge i_core_clk) #1;
		got = rsp;
		req = '0;
	endtask
	task automatic rd(input logic [7:0] n, input logic [7:0] e, input logic h);
		access(1'b0, n, 8'h00);
		chk("rsp_valid", 12'h1, {11'h0, got.valid});
		chk("rsp_hit", {11'h0, h}, {11'h0, got.hit});
		chk("rsp_data", {4'h0, e}, {4'h0, got.data});
		chk("rsp_digits", bcd(e), got.digits);
	endtask
	task automatic wr(input int i, input logic [7:0] d);
		access(1'b1, REG_NUM[i], d);
		chk("wr_old", {4'h0, mdl[i]}, {4'h0, got.data});
		mdl[i] = d;
	endtask
	task automatic drain;
		repeat (30) @(posedge i_core_clk);
		#1;
		chk("tx_count", 12'(exp_q.size()), 12'(i_host.got_q.size()));
		for (int k = 0; k < exp_q.size() && k < i_host.got_q.size(); k++) begin
			chk("tx_code", {4'h0, exp_q[k]}, {4'h0, i_host.got_q[k]});
		end
		exp_q.delete();
		i_host.got_q.delete();
	endtask
	task automatic erase(input logic [7:0] c, input logic e);
		@(posedge i_core_clk) #1;
		rx = '{valid: 1'b1, code: c};
		#1 chk("erase_hit", {11'h0, e}, {11'h0, hit});
		@(posedge i_core_clk) #1;
		rx = '0;
		if (e) begin
			exp_q = '{c, 8'h20, c};
		end
		drain();
	endtask
	task automatic result(input logic [7:0] gen, input int n);
		wr(IX_GEN, gen);
		@(posedge i_core_clk) #1;
		res_end = 1'b1;
		@(posedge i_core_clk) #1;
		res_end = 1'b0;
		if (n > 0) exp_q.push_back(mdl[IX_TERM]);
		if (n > 1) exp_q.push_back(mdl[IX_LF]);
		drain();
	endtask
	task automatic pulse(input int b);
		@(posedge i_core_clk) #1;
		z[b] = 1'b1;
		@(posedge i_core_clk) #1;
		z[b] = 1'b0;
	endtask
	initial begin
		#3000000;
		n_fail++;
		end_of_test();
	end
	initial begin
		void'($urandom(3));
		mdl = rst_tab;
		repeat (4) @(posedge i_core_clk);
		#1 i_rst = 1'b0;
		for (int i = 0; i < NREG; i++) rd(REG_NUM[i], mdl[i], 1'b1);
		for (int i = 0; i < NREG; i++) if (i != IX_TEST) wr(i, 8'($urandom));
		access(1'b1, 8'h0d, 8'h55);
		rd(8'h0d, 8'h00, 1'b0);
		for (int i = 0; i < NREG; i++) rd(REG_NUM[i], mdl[i], 1'b1);
		for (int i = 0; i < NREG; i++) if (i != IX_TEST) wr(i, rst_tab[i]);
		erase(8'h08, 1'b1);
		wr(IX_ERASE, 8'h21);
		erase(8'h21, 1'b0);
		wr(IX_ERASE, 8'h20);
		erase(8'h20, 1'b1);
		result(8'h8a, 2);
		result(8'h82, 1);
		result(8'h8e, 0);
		wr(IX_TERM, 8'h2a);
		wr(IX_LF, 8'h0c);
		result(8'h8a, 2);
		wr(IX_SYNC, 8'h01);
		result(8'h8a, 0);
		wr(IX_SYNC, 8'h09);
		wr(IX_GUARD, 8'h02);
		pulse(9);
		chk("esc_first", 12'h0, {11'h0, esc_ok});
		repeat (20) @(posedge i_core_clk);
		pulse(9);
		chk("esc_near", 12'h1, {11'h0, esc_ok});
		repeat (200) @(posedge i_core_clk);
		pulse(9);
		chk("esc_far", 12'h0, {11'h0, esc_ok});
		wr(IX_TDUR, 8'h02);
		z[23:16] = 8'h41;
		pulse(10);
		rd(REG_NUM[IX_TEST], 8'h41, 1'b1);
		chk("test_on", 12'h1, {11'h0, t_act});
		repeat (820) @(posedge i_core_clk);
		#1 chk("test_timed", 12'h0, {11'h0, t_act});
		rd(REG_NUM[IX_TEST], 8'h00, 1'b1);
		wr(IX_TDUR, 8'h00);
		pulse(10);
		repeat (900) @(posedge i_core_clk);
		#1 chk("test_held", 12'h1, {11'h0, t_act});
		pulse(11);
		rd(REG_NUM[IX_TEST], 8'h00, 1'b1);
		chk("test_off", 12'h0, {11'h0, t_act});
		wr(IX_SER, 8'h00);
		wr(IX_SYNC, 8'h01);
		wr(IX_CTS, 8'h03);
		chk("cts_idle", 12'h0, {11'h0, cts});
		z[13] = 1'b1;
		repeat (8) @(posedge i_core_clk);
		#1 chk("cts_delay", 12'h0, {11'h0, cts});
		repeat (20) @(posedge i_core_clk);
		#1 chk("cts_raised", 12'h1, {11'h0, cts});
		z[13] = 1'b0;
		wr(IX_SYNC, 8'h09);
		wr(IX_CTS, 8'h01);
		chk("cts_async", 12'h1, {11'h0, cts});
		wr(IX_SER, 8'h04);
		z[13] = 1'b1;
		repeat (4) @(posedge i_core_clk);
		#1 chk("cts_track", 12'h1, {11'h0, cts});
		z[13] = 1'b0;
		wr(IX_DIAL, 8'h00);
		pulse(0);
		repeat (700) @(posedge i_core_clk);
		#1 chk("dial_early", 12'h0, 12'(n_go));
		repeat (600) @(posedge i_core_clk);
		#1 chk("dial_go", 12'h1, 12'(n_go));
		wr(IX_SLEEP, 8'h02);
		pulse(12);
		repeat (3900) @(posedge i_core_clk);
		#1 chk("sleep_early", 12'h0, {11'h0, slp});
		repeat (4300) @(posedge i_core_clk);
		#1 chk("sleep_on", 12'h1, {11'h0, slp});
		pulse(12);
		chk("sleep_wake", 12'h0, {11'h0, slp});
		carrier = 1'b1;
		online = 1'b1;
		repeat (150) @(posedge i_core_clk);
		#1 chk("cd_early", 12'h0, {11'h0, det});
		repeat (180) @(posedge i_core_clk);
		#1 chk("cd_late", 12'h1, {11'h0, det});
		carrier = 1'b0;
		repeat (250) @(posedge i_core_clk);
		#1 chk("hup_early", 12'(HUP_NONE), 12'(cause));
		repeat (170) @(posedge i_core_clk);
		#1 chk("hup_lost", 12'(HUP_CARRIER_LOST), 12'(cause));
		dtr = 1'b0;
		repeat (12) @(posedge i_core_clk);
		#1 chk("hup_dtr_early", 12'(HUP_CARRIER_LOST), 12'(cause));
		repeat (30) @(posedge i_core_clk);
		#1 chk("hup_dtr", 12'(HUP_DTR), 12'(cause));
		end_of_test();
	end
endmodule // testbench
`default_nettype wire
